// [src/dbcmd_top.sv]
// Purpose: Decodes host command words and carries out detector board actions.
// Assumes: Request and reply use valid/ready; peripherals take one-cycle strobes.
// Notes:   Gain and threshold settings are mirrored here and driven out as vectors.
`default_nettype none
module dbcmd_top #(
  parameter logic [15:0] NODE_ADDR  = 16'h0001,
  parameter logic [7:0]  VER_MAJOR  = 8'h01,  // Arbitrary value.
  parameter logic [7:0]  VER_MINOR  = 8'h00,  // Arbitrary value.
  parameter logic [3:0]  VER_SUB    = 4'h0    // Arbitrary value.
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire dbcmd_pkg::dbcmd_word_t      cmd_word,
  output logic                             rsp_valid,
  input  wire logic                        rsp_ready,
  output dbcmd_pkg::dbcmd_word_t           rsp_word,
  output logic                             sram_we,
  output logic [dbcmd_pkg::DBCMD_SRAM_AW-1:0] sram_addr,
  output logic [31:0]                      sram_wdata,
  output logic [31:0]                      time_converter_control,
  output logic                             adc_wr_strobe,
  output logic [1:0]                       adc_wr_chips,
  output dbcmd_pkg::dbcmd_adc_wr_t         adc_wr,
  output logic [63:0]                      adc_gain,
  output logic [159:0]                     dac_energy,
  output logic [159:0]                     dac_timing,
  output logic [3:0]                       saw_pulse_energy,
  output logic [3:0]                       saw_pulse_timing
);
  import dbcmd_pkg::*;

  typedef enum {DBCMD_IDLE, DBCMD_CLEAR, DBCMD_SAW, DBCMD_REPLY} dbcmd_state_t;

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Type match used by both threshold writes and sawtooth selection.
  function automatic logic type_hits(input logic [1:0] typ, input logic [1:0] want);
    type_hits = (typ == want) || (typ == DBCMD_TYPE_ALL);
  endfunction

  function automatic logic chip_hits(input logic [3:0] chip, input int idx, input logic bcast);
    chip_hits = bcast || (chip == 4'(idx));
  endfunction

  dbcmd_state_t state;
  dbcmd_word_t  req;
  logic [31:0]  rsp_payload;
  logic         reply_wanted;
  logic [7:0]   saw_left;
  logic [15:0]  saw_timer;
  logic [3:0]   saw_chip;
  logic [1:0]   saw_type;
  logic         saw_bcast;
  logic         saw_fire;

  logic accept;
  logic for_me;
  logic [15:0] cid;
  logic [31:0] pl;
  // Ready waits for the internal reset to lift, so no word is taken and then lost.
  assign cmd_ready = (state == DBCMD_IDLE) && rst_n;
  assign accept    = cmd_valid && cmd_ready;
  assign for_me    = cmd_word.dest[DBCMD_DEST_BCAST] || (cmd_word.dest == NODE_ADDR);
  assign cid       = {1'b0, cmd_word.id[14:0]};  // Top bit only marks non-blocking.
  assign pl        = cmd_word.payload;

  logic do_sysrst;
  logic do_adcrst;
  logic do_dacrst;
  assign do_sysrst = accept && for_me && (cid == DBCMD_SYS_RESET);
  assign do_adcrst = do_sysrst || (accept && for_me && (cid == DBCMD_ADC_RESET));
  assign do_dacrst = do_sysrst || (accept && for_me && (cid == DBCMD_DAC_RESET));

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  logic cmd_hit;
  assign cmd_hit = accept && for_me;

  // One command at a time: ready stays low until the reply has been taken.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DBCMD_IDLE;
    end else begin
      case (state)
        DBCMD_IDLE: begin
          if (cmd_hit && (cid == DBCMD_SRAM_CLEAR)) begin
            state <= DBCMD_CLEAR;
          end else if (cmd_hit && (cid == DBCMD_SAWTOOTH) && (pl[DBCMD_SAW_CNT_LSB +: 8] != 8'h00)) begin
            state <= DBCMD_SAW;
          end else if (cmd_hit) begin
            state <= DBCMD_REPLY;
          end
        end
        DBCMD_CLEAR: begin
          if (sram_addr == {DBCMD_SRAM_AW{1'b1}}) begin
            state <= DBCMD_REPLY;
          end
        end
        DBCMD_SAW: begin
          if ((saw_timer == 16'(DBCMD_PULSE_CYC - 1)) && (saw_left == 8'h01)) begin
            state <= DBCMD_REPLY;
          end
        end
        DBCMD_REPLY: begin
          if (!reply_wanted || rsp_ready) begin
            state <= DBCMD_IDLE;
          end
        end
        default: state <= DBCMD_IDLE;
      endcase
    end
  end

  // Reply fields are captured at acceptance so later inputs cannot disturb them.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req          <= '0;
      reply_wanted <= 1'b0;
      rsp_payload  <= '0;
    end else if (cmd_hit) begin
      req          <= cmd_word;
      // Under broadcast only the node named by the low bits answers.
      reply_wanted <= ({1'b0, cmd_word.dest[14:0]} == NODE_ADDR);
      case (cid)
        DBCMD_NODE_TYPE: rsp_payload <= {28'h0, DBCMD_DETECTOR_BOARD_NODE};
        DBCMD_VERSION:   rsp_payload <= {12'h0, VER_MAJOR, VER_MINOR, VER_SUB};
        DBCMD_TC_WRITE:  rsp_payload <= {24'h0, pl[7:0]};
        DBCMD_TC_READ:   rsp_payload <= time_converter_control;
        DBCMD_ADC_WRITE: rsp_payload <= pl;
        DBCMD_DAC_WRITE: rsp_payload <= pl;
        DBCMD_SAWTOOTH:  rsp_payload <= pl;
        default:         rsp_payload <= '0;
      endcase
    end
  end

  // The sweep wraps back to zero on its last write, ready for the next clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_addr <= '0;
    end else if (state == DBCMD_CLEAR) begin
      sram_addr <= sram_addr + 1'b1;
    end else begin
      sram_addr <= '0;
    end
  end

  // A long train stalls the command path until its last pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      saw_left  <= '0;
      saw_timer <= '0;
      saw_chip  <= '0;
      saw_type  <= '0;
      saw_bcast <= 1'b0;
    end else if (cmd_hit && (cid == DBCMD_SAWTOOTH)) begin
      saw_chip  <= pl[DBCMD_SAW_CHIP_LSB +: 4];
      saw_type  <= pl[DBCMD_SAW_TYPE_LSB +: 2];
      saw_left  <= pl[DBCMD_SAW_CNT_LSB +: 8];
      saw_bcast <= pl[DBCMD_BCAST_BIT];
      saw_timer <= '0;
    end else if (state == DBCMD_SAW) begin
      if (saw_timer == 16'(DBCMD_PULSE_CYC - 1)) begin
        saw_timer <= '0;
        saw_left  <= saw_left - 1'b1;
      end else begin
        saw_timer <= saw_timer + 1'b1;
      end
    end
  end

  assign sram_we    = (state == DBCMD_CLEAR);
  assign sram_wdata = 32'h0000_0000;
  // Each pulse is high for the first half of its period.
  assign saw_fire   = (state == DBCMD_SAW) && (saw_timer < 16'(DBCMD_PULSE_CYC / 2));

  // ==========================================================================
  // Reply
  // ==========================================================================
  assign rsp_valid        = (state == DBCMD_REPLY) && reply_wanted;
  assign rsp_word.id      = req.id | 16'(1 << DBCMD_REPLY_BIT);
  assign rsp_word.dest    = req.dest;
  assign rsp_word.payload = rsp_payload;

  // ==========================================================================
  // Time converter control
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_converter_control <= DBCMD_TC_CTRL_RST;
    end else if (do_sysrst) begin
      time_converter_control <= DBCMD_TC_CTRL_RST;
    end else if (accept && for_me && (cid == DBCMD_TC_WRITE)) begin
      time_converter_control <= {24'h0, pl[7:0]};
    end
  end

  // ==========================================================================
  // ADC configuration
  // ==========================================================================
  logic adc_go;
  assign adc_go = accept && for_me && (cid == DBCMD_ADC_WRITE);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_wr_strobe <= 1'b0;
      adc_wr_chips  <= '0;
      adc_wr        <= '0;
    end else begin
      adc_wr_strobe <= adc_go;
      if (adc_go) begin
        adc_wr.adc_data <= pl[DBCMD_ADC_DATA_LSB +: 16];
        adc_wr.adc_addr <= pl[DBCMD_ADC_ADDR_LSB +: 8];
        adc_wr.adc_chip <= pl[DBCMD_ADC_CHIP_BIT];
        adc_wr_chips    <= pl[DBCMD_BCAST_BIT] ? 2'b11 :
                           (pl[DBCMD_ADC_CHIP_BIT] ? 2'b10 : 2'b01);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < DBCMD_ADC_CHIPS; g++) begin : g_adc
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          adc_gain[g*32 +: 32] <= {2{DBCMD_ADC_GAIN_RST}};
        end else if (do_adcrst) begin
          adc_gain[g*32 +: 32] <= {2{DBCMD_ADC_GAIN_RST}};
        end else if (adc_go && (pl[DBCMD_BCAST_BIT] || (pl[DBCMD_ADC_CHIP_BIT] == 1'(g)))) begin
          // Lower group packs channel 3 down to 0; the upper group reverses order.
          if (pl[DBCMD_ADC_ADDR_LSB +: 8] == DBCMD_ADC_GAIN_LO) begin
            adc_gain[g*32 +: 16] <= pl[15:0];
          end else if (pl[DBCMD_ADC_ADDR_LSB +: 8] == DBCMD_ADC_GAIN_HI) begin
            adc_gain[g*32+16 +: 16] <= {pl[3:0], pl[7:4], pl[11:8], pl[15:12]};
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Threshold DACs
  // ==========================================================================
  logic       dac_go;
  logic [1:0] dac_type;
  logic [3:0] dac_chip;
  logic [3:0] dac_addr;
  assign dac_go   = accept && for_me && (cid == DBCMD_DAC_WRITE)
                    && (pl[DBCMD_DAC_CMD_LSB +: 4] == DBCMD_DAC_CMD_SET);
  assign dac_type = pl[DBCMD_DAC_TYPE_LSB +: 2];
  assign dac_chip = pl[DBCMD_DAC_CHIP_LSB +: 4];
  assign dac_addr = pl[DBCMD_DAC_ADDR_LSB +: 4];

  genvar c;
  generate
    for (c = 0; c < 4 * DBCMD_DAC_CHIPS; c++) begin : g_dac
      logic hit;
      // Channel c lives on chip c/4 at address c mod 4.
      assign hit = dac_go && chip_hits(dac_chip, c / 4, pl[DBCMD_BCAST_BIT])
                   && ((dac_addr == 4'(c % 4)) || (dac_addr == DBCMD_DAC_ADDR_ALL));
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          dac_energy[c*10 +: 10] <= DBCMD_DAC_RST;
          dac_timing[c*10 +: 10] <= DBCMD_DAC_RST;
        end else if (do_dacrst) begin
          dac_energy[c*10 +: 10] <= DBCMD_DAC_RST;
          dac_timing[c*10 +: 10] <= DBCMD_DAC_RST;
        end else if (hit) begin
          if (type_hits(dac_type, DBCMD_TYPE_ENERGY)) begin
            dac_energy[c*10 +: 10] <= pl[DBCMD_DAC_DATA_LSB +: 10];
          end
          if (type_hits(dac_type, DBCMD_TYPE_TIMING)) begin
            dac_timing[c*10 +: 10] <= pl[DBCMD_DAC_DATA_LSB +: 10];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Sawtooth outputs
  // ==========================================================================
  genvar s;
  generate
    for (s = 0; s < DBCMD_DAC_CHIPS; s++) begin : g_saw
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          saw_pulse_energy[s] <= 1'b0;
          saw_pulse_timing[s] <= 1'b0;
        end else begin
          saw_pulse_energy[s] <= saw_fire && chip_hits(saw_chip, s, saw_bcast)
                                 && type_hits(saw_type, DBCMD_TYPE_ENERGY);
          saw_pulse_timing[s] <= saw_fire && chip_hits(saw_chip, s, saw_bcast)
                                 && type_hits(saw_type, DBCMD_TYPE_TIMING);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [src/dbcmd_pkg.sv]
// Purpose: Shared constants and carriers for the detector board command interpreter.
// Assumes: One 100 MHz clock; words arrive already framed by the transport.
// Notes:   Offsets are command IDs; field positions are payload bit numbers.
`default_nettype none
package dbcmd_pkg;
  // ==========================================================================
  // Command IDs and reply marking
  // ==========================================================================
  localparam logic [15:0] DBCMD_SRAM_CLEAR   = 16'h000D;
  localparam logic [15:0] DBCMD_SYS_RESET    = 16'h000F;
  localparam logic [15:0] DBCMD_NODE_TYPE    = 16'h0010;
  localparam logic [15:0] DBCMD_VERSION      = 16'h0011;
  localparam logic [15:0] DBCMD_TC_WRITE     = 16'h0101;
  localparam logic [15:0] DBCMD_TC_READ      = 16'h0102;
  localparam logic [15:0] DBCMD_ADC_RESET    = 16'h0103;
  localparam logic [15:0] DBCMD_ADC_WRITE    = 16'h0104;
  localparam logic [15:0] DBCMD_DAC_RESET    = 16'h0105;
  localparam logic [15:0] DBCMD_DAC_WRITE    = 16'h0106;
  localparam logic [15:0] DBCMD_SAWTOOTH     = 16'h0107;
  localparam int          DBCMD_REPLY_BIT    = 15;
  localparam int          DBCMD_BCAST_BIT    = 31;
  localparam int          DBCMD_DEST_BCAST   = 15;
  // ==========================================================================
  // Node roles
  // ==========================================================================
  localparam logic [3:0]  DBCMD_CENTRAL_CONTROLLER_NODE  = 4'h0;
  localparam logic [3:0]  DBCMD_MULTIPLEXER_BOARD_NODE   = 4'h1;
  localparam logic [3:0]  DBCMD_UNIT_CONTROLLER_NODE     = 4'h2;
  localparam logic [3:0]  DBCMD_DETECTOR_BOARD_NODE      = 4'h3;
  localparam logic [3:0]  DBCMD_COMBINED_CONTROLLER_NODE = 4'h4;
  // ==========================================================================
  // Time converter control
  // ==========================================================================
  localparam logic [7:0]  DBCMD_TC_RESET     = 8'h80;
  localparam logic [7:0]  DBCMD_TC_CALIBRATE = 8'h02;
  localparam logic [7:0]  DBCMD_TC_RUN       = 8'h04;
  localparam logic [31:0] DBCMD_TC_CTRL_RST  = 32'h0000_0000;
  // ==========================================================================
  // ADC and DAC fields
  // ==========================================================================
  localparam int          DBCMD_ADC_DATA_LSB = 0;
  localparam int          DBCMD_ADC_ADDR_LSB = 18;
  localparam int          DBCMD_ADC_CHIP_BIT = 27;
  localparam logic [7:0]  DBCMD_ADC_GAIN_LO  = 8'h2A;
  localparam logic [7:0]  DBCMD_ADC_GAIN_HI  = 8'h2B;
  localparam logic [15:0] DBCMD_ADC_GAIN_RST = 16'h0000;
  localparam int          DBCMD_DAC_DATA_LSB = 0;
  localparam int          DBCMD_DAC_ADDR_LSB = 13;
  localparam int          DBCMD_DAC_CMD_LSB  = 17;
  localparam int          DBCMD_DAC_CHIP_LSB = 23;
  localparam int          DBCMD_DAC_TYPE_LSB = 27;
  localparam logic [3:0]  DBCMD_DAC_CMD_SET  = 4'h3;
  localparam logic [3:0]  DBCMD_DAC_ADDR_ALL = 4'hF;
  localparam logic [1:0]  DBCMD_TYPE_ENERGY  = 2'b00;
  localparam logic [1:0]  DBCMD_TYPE_TIMING  = 2'b01;
  localparam logic [1:0]  DBCMD_TYPE_ALL     = 2'b11;
  localparam logic [9:0]  DBCMD_DAC_RST      = 10'h000;
  localparam int          DBCMD_SAW_CHIP_LSB = 0;
  localparam int          DBCMD_SAW_TYPE_LSB = 4;
  localparam int          DBCMD_SAW_CNT_LSB  = 6;
  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int          DBCMD_SRAM_AW      = 16;
  localparam int          DBCMD_DAC_CHIPS    = 4;
  localparam int          DBCMD_ADC_CHIPS    = 2;
  localparam int          DBCMD_CLK_MHZ      = 100;
  localparam int          DBCMD_PULSE_NS     = 1000;
  localparam int          DBCMD_PULSE_CYC    = (DBCMD_PULSE_NS * DBCMD_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [15:0] id;
    logic [15:0] dest;
    logic [31:0] payload;
  } dbcmd_word_t;

  typedef struct packed {
    logic        adc_chip;
    logic [7:0]  adc_addr;
    logic [15:0] adc_data;
  } dbcmd_adc_wr_t;
endpackage
`default_nettype wire

// [sim/dbcmd_chk.sv]
// Purpose: Port-level assertions for the command interpreter.
// Assumes: One clock domain; NODE_ADDR matches the design instance.
// Notes:   Reply checks only look at words addressed to this node.
`default_nettype none
module dbcmd_chk #(
  parameter logic [15:0] NODE_ADDR = 16'h0001
) (
  input wire logic                     sys_clk,
  input wire logic                     reset_n,
  input wire logic                     cmd_valid,
  input wire logic                     cmd_ready,
  input wire dbcmd_pkg::dbcmd_word_t   cmd_word,
  input wire logic                     rsp_valid,
  input wire logic                     rsp_ready,
  input wire dbcmd_pkg::dbcmd_word_t   rsp_word,
  input wire logic                     sram_we,
  input wire logic [31:0]              sram_wdata,
  input wire logic [31:0]              time_converter_control,
  input wire logic                     adc_wr_strobe,
  input wire logic [1:0]               adc_wr_chips,
  input wire dbcmd_pkg::dbcmd_adc_wr_t adc_wr
);
  import dbcmd_pkg::*;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic        acc;
  logic        mine;
  logic [14:0] op;
  assign acc  = cmd_valid && cmd_ready;
  assign mine = cmd_word.dest == NODE_ADDR;
  assign op   = cmd_word.id[14:0];
  AST_REPLY_MARK: assert property (rsp_valid |-> rsp_word.id[15])
    else $error("reply id lacks its reply mark");
  AST_REPLY_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word))
    else $error("reply dropped or changed before it was taken");
  AST_REPLY_ECHO: assert property (acc && mine && op == DBCMD_NODE_TYPE[14:0] |=>
    rsp_valid && rsp_word.dest == $past(cmd_word.dest) && rsp_word.id == ($past(cmd_word.id) | 16'h8000))
    else $error("reply does not echo the request");
  AST_NODE_ROLE: assert property (acc && mine && op == DBCMD_NODE_TYPE[14:0] |=> rsp_word.payload == 32'h3)
    else $error("node type reply is not the detector board code");
  AST_SRAM_ZERO: assert property (acc && mine && op == DBCMD_SRAM_CLEAR[14:0] |=>
    (sram_we && sram_wdata == 32'h0) [*8])
    else $error("clear does not start writing zeros");
  AST_TC_WRITE: assert property (acc && (mine || cmd_word.dest[15]) && op == DBCMD_TC_WRITE[14:0] |=>
    time_converter_control == {24'h0, $past(cmd_word.payload[7:0])})
    else $error("time converter control not loaded from the low byte");
  AST_ADC_FIELDS: assert property (acc && mine && op == DBCMD_ADC_WRITE[14:0] |=> adc_wr_strobe &&
    adc_wr == {$past(cmd_word.payload[27]), $past(cmd_word.payload[25:18]), $past(cmd_word.payload[15:0])})
    else $error("converter write fields misplaced");
  AST_ADC_CHIPS: assert property (acc && mine && op == DBCMD_ADC_WRITE[14:0] |=>
    adc_wr_chips == ($past(cmd_word.payload[31]) ? 2'b11 : ($past(cmd_word.payload[27]) ? 2'b10 : 2'b01)))
    else $error("converter write reaches the wrong chips");
  AST_TC_UPPER: assert property (time_converter_control[31:8] == 24'h0)
    else $error("time converter control upper bits set");
endmodule
bind dbcmd_top dbcmd_chk #(.NODE_ADDR(NODE_ADDR)) u_chk (.sys_clk, .reset_n, .cmd_valid, .cmd_ready,
  .cmd_word, .rsp_valid, .rsp_ready, .rsp_word, .sram_we, .sram_wdata, .time_converter_control,
  .adc_wr_strobe, .adc_wr_chips, .adc_wr);
`default_nettype wire

// [sim/dbcmd_host.sv]
// Purpose: Host model that sends command words and takes replies.
// Assumes: Replies are taken after a stall of one to three cycles, one fixed plus a random zero to two.
// Notes:   A released word shows its inverse so stale data is never mistaken.
`default_nettype none
module dbcmd_host (
  input  wire logic                   sys_clk,
  input  wire logic                   cmd_ready,
  input  wire logic                   rsp_valid,
  input  wire dbcmd_pkg::dbcmd_word_t rsp_word,
  output logic                        cmd_valid,
  output dbcmd_pkg::dbcmd_word_t      cmd_word,
  output logic                        rsp_ready
);
  import dbcmd_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = '0;
    rsp_ready = 1'b0;
  end
  // A sawtooth request carries the top bit of its id; the design masks it off, so the train still blocks.
  task automatic xfer(input dbcmd_word_t w, input bit want, output dbcmd_word_t r, output bit ok);
    int n;
    n = 0;
    r = '0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_word  <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    cmd_word  <= ~w;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < (want ? 70000 : 6));
    ok = (rsp_valid === 1'b1) == want;
    if (want && ok) begin
      r = rsp_word;
      repeat ($urandom_range(2)) @(posedge sys_clk);
      @(posedge sys_clk);
      rsp_ready <= 1'b1;
      @(posedge sys_clk);
      rsp_ready <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [sim/dbcmd_top_test.sv]
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Node address 1; version parameters are arbitrary values.
// Notes:   The SRAM clear dominates the run at 65536 write cycles.
`default_nettype none
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, ac); end end
module dbcmd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dbcmd_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready, sram_we, adc_wr_strobe;
  dbcmd_word_t    cmd_word, rsp_word, rsp;
  dbcmd_adc_wr_t  adc_wr;
  logic [15:0]    sram_addr, d16;
  logic [31:0]    sram_wdata, time_converter_control, p;
  logic [1:0]     adc_wr_chips, saw_q;
  logic [63:0]    adc_gain, gain_m;
  logic [159:0]   dac_energy, dac_timing, e_m, t_m;
  logic [3:0]     saw_pulse_energy, saw_pulse_timing;
  logic [7:0]     tcc [3] = '{DBCMD_TC_RESET, DBCMD_TC_CALIBRATE, DBCMD_TC_RUN};
  int             error_cnt, n_checks, sram_cnt, saw_cnt;
  always #5 sys_clk = ~sys_clk;
  dbcmd_top #(.VER_MAJOR(8'h05), .VER_MINOR(8'h0A), .VER_SUB(4'h7)) i_dut (.sys_clk, .reset_n, .cmd_valid,
    .cmd_ready, .cmd_word, .rsp_valid, .rsp_ready, .rsp_word, .sram_we, .sram_addr, .sram_wdata,
    .time_converter_control, .adc_wr_strobe, .adc_wr_chips, .adc_wr, .adc_gain, .dac_energy, .dac_timing,
    .saw_pulse_energy, .saw_pulse_timing);
  dbcmd_host i_host (.sys_clk, .cmd_ready, .rsp_valid, .rsp_word, .cmd_valid, .cmd_word, .rsp_ready);
  always @(posedge sys_clk) begin
    if (sram_we === 1'b1 && sram_addr === 16'(sram_cnt)) sram_cnt++;
    saw_q <= {saw_pulse_timing[3], saw_pulse_energy[0]};
    if (saw_pulse_energy[0] === 1'b1 && saw_q[0] === 1'b0) saw_cnt++;
    if (saw_pulse_timing[3] === 1'b1 && saw_q[1] === 1'b0) saw_cnt += 16;
  end
  // ==========================================================================
  // Tasks and expectations
  // ==========================================================================
  function automatic logic [15:0] grp(input logic hi, input logic [15:0] d);
    return hi ? {d[3:0], d[7:4], d[11:8], d[15:12]} : d;
  endfunction
  task automatic run(input logic [15:0] id, input logic [15:0] dest, input logic [31:0] pl, input bit want);
    bit ok;
    i_host.xfer({id, dest, pl}, want, rsp, ok);
    `CHK("reply presence", 1'b1, ok)
    if (want) begin
      `CHK("reply id", id | 16'h8000, rsp.id)
      `CHK("reply dest", dest, rsp.dest)
    end
  endtask
  task automatic dac_wr(input logic [1:0] ty, input logic [3:0] chip, input logic [3:0] addr,
                        input logic [3:0] cv, input logic bc);
    logic [9:0] d;
    d = $urandom;
    run(DBCMD_DAC_WRITE, 16'h0001, {bc, 2'b00, ty, chip, 2'b00, cv, addr, 3'b000, d}, 1'b1);
    for (int c = 0; c < 16; c++)
      if (cv == DBCMD_DAC_CMD_SET && (bc || c / 4 == chip) && (addr == 4'hF || c % 4 == addr)) begin
        if (ty == 2'b00 || ty == 2'b11) e_m[c*10 +: 10] = d;
        if (ty == 2'b01 || ty == 2'b11) t_m[c*10 +: 10] = d;
      end
    `CHK("energy dac", e_m, dac_energy)
    `CHK("timing dac", t_m, dac_timing)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    #900000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    void'($urandom(56452));
    gain_m = '0;
    e_m = '0;
    t_m = '0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int a = 0; a < 4; a++) begin
      run(DBCMD_NODE_TYPE, 16'(a), $urandom, a == 1);
      if (a == 1) `CHK("node type", 32'h3, rsp.payload)
    end
    run(DBCMD_VERSION, 16'h0001, $urandom, 1'b1);
    `CHK("version", 32'h0005_0A7, rsp.payload)
    $display("test identity done");
    foreach (tcc[i]) begin
      p = $urandom;
      p[7:0] = tcc[i];
      run(DBCMD_TC_WRITE, 16'h0001, p, 1'b1);
      `CHK("tc reg", {24'h0, tcc[i]}, time_converter_control)
      run(DBCMD_TC_READ, 16'h0001, $urandom, 1'b1);
      `CHK("tc read", {24'h0, tcc[i]}, rsp.payload)
    end
    run(DBCMD_TC_WRITE, 16'h8002, 32'h0000_0002, 1'b0);
    `CHK("tc by broadcast", 32'h2, time_converter_control)
    run(DBCMD_TC_WRITE, 16'h0002, 32'h0000_0080, 1'b0);
    `CHK("tc other node", 32'h2, time_converter_control)
    $display("test time converter done");
    for (int i = 0; i < 5; i++) begin
      d16 = $urandom;
      p = {i == 4, 3'b000, i[0], 1'b0, i[1] ? DBCMD_ADC_GAIN_HI : DBCMD_ADC_GAIN_LO, 2'b00, d16};
      for (int c = 0; c < 2; c++)
        if (i == 4 || c == i % 2) gain_m[c*32 + (i[1] ? 16 : 0) +: 16] = grp(i[1], d16);
      run(DBCMD_ADC_WRITE, 16'h0001, p, 1'b1);
      `CHK("adc gain", gain_m, adc_gain)
    end
    run(DBCMD_ADC_RESET, 16'h0001, $urandom, 1'b1);
    `CHK("adc reset reply", 32'h0, rsp.payload)
    `CHK("adc gain after reset", 64'h0, adc_gain)
    $display("test adc done");
    dac_wr(2'b00, 4'h1, 4'h0, DBCMD_DAC_CMD_SET, 1'b0);
    dac_wr(2'b01, 4'h3, 4'h0, DBCMD_DAC_CMD_SET, 1'b1);
    dac_wr(2'b11, 4'h2, 4'hF, DBCMD_DAC_CMD_SET, 1'b0);
    dac_wr(2'b10, 4'h0, 4'h1, DBCMD_DAC_CMD_SET, 1'b0);
    dac_wr(2'b00, 4'h0, 4'h2, 4'h2, 1'b0);
    run(DBCMD_DAC_RESET, 16'h0001, $urandom, 1'b1);
    `CHK("dac reset reply", 32'h0, rsp.payload)
    `CHK("dac after reset", 320'h0, {dac_energy, dac_timing})
    $display("test dac done");
    saw_cnt = 0;
    run(16'h8107, 16'h0001, {1'b0, 17'h0, 8'd3, 2'b00, 4'h0}, 1'b1);
    `CHK("sawtooth pulses", 3, saw_cnt)
    saw_cnt = 0;
    run(16'h8107, 16'h0001, {1'b1, 17'h0, 8'd2, 2'b01, 4'h0}, 1'b1);
    `CHK("sawtooth timing pulses", 32, saw_cnt)
    $display("test sawtooth done");
    sram_cnt = 0;
    run(DBCMD_SRAM_CLEAR, 16'h0001, $urandom, 1'b1);
    `CHK("sram writes", 65536, sram_cnt)
    `CHK("sram reply", 32'h0, rsp.payload)
    $display("test sram clear done");
    e_m = '0;
    t_m = '0;
    dac_wr(2'b11, 4'h0, 4'hF, DBCMD_DAC_CMD_SET, 1'b1);
    run(DBCMD_ADC_WRITE, 16'h0001, {6'h0, DBCMD_ADC_GAIN_LO, 18'h0_5555}, 1'b1);
    run(DBCMD_SYS_RESET, 16'h8001, $urandom, 1'b1);
    `CHK("sys reset reply", 32'h0, rsp.payload)
    `CHK("sys reset state", 416'h0, {time_converter_control, adc_gain, dac_energy, dac_timing})
    $display("test system reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
